// ---- rtl/sleep_cfg.svh ----
// Encodings and timing counts shared by the sleep controller files.
// Assumes it is included by bare name, through the package.
`ifndef SLEEP_CFG_SVH
`define SLEEP_CFG_SVH
// Mode select encodings.
`define SLP_SEL_IDLE 3'h0
`define SLP_SEL_QUIET 3'h1
`define SLP_SEL_PDOWN 3'h2
`define SLP_SEL_PSAVE 3'h3
`define SLP_SEL_RSV4 3'h4
`define SLP_SEL_RSV5 3'h5
`define SLP_SEL_STBY 3'h6
`define SLP_SEL_XSTBY 3'h7
// Run state codes, Gray along active, sleep, start-up, halt.
`define SLP_ST_ACTIVE 2'h0
`define SLP_ST_SLEEP 2'h1
`define SLP_ST_STARTUP 2'h3
`define SLP_ST_HALT 2'h2
// Clock restart period after the deep modes, in mclk cycles.
`define SLP_STARTUP_CYCLES 16'h4000
// Wake time from the standby modes, in mclk cycles.
`define SLP_STANDBY_WAKE 16'h0006
// Halt cycles after start-up before the interrupt is serviced.
`define SLP_HALT_CYCLES 16'h0004
// No start-up wait at all.
`define SLP_NO_WAIT 16'h0000
// Clock source select bit that marks a crystal or resonator.
`define SLP_XTAL_BIT 3
`endif

// ---- rtl/sleep_pkg.sv ----
// Types shared by the sleep controller and its helpers.
// Assumes sleep_cfg.svh is on the include path.
`include "sleep_cfg.svh"
package sleep_pkg;
	// =====================================================
	// Modes and states
	typedef enum logic [2:0] {
		MODE_IDLE = `SLP_SEL_IDLE,
		MODE_QUIET = `SLP_SEL_QUIET,
		MODE_PDOWN = `SLP_SEL_PDOWN,
		MODE_PSAVE = `SLP_SEL_PSAVE,
		MODE_RSV4 = `SLP_SEL_RSV4,
		MODE_RSV5 = `SLP_SEL_RSV5,
		MODE_STBY = `SLP_SEL_STBY,
		MODE_XSTBY = `SLP_SEL_XSTBY
	} mode_t;
	typedef enum logic [1:0] {
		ST_ACTIVE = `SLP_ST_ACTIVE,
		ST_SLEEP = `SLP_ST_SLEEP,
		ST_STARTUP = `SLP_ST_STARTUP,
		ST_HALT = `SLP_ST_HALT
	} run_state_t;
	// =====================================================
	// Carriers
	// Clock and oscillator enables, one means running.
	typedef struct packed {
		logic core_clock_domain;
		logic program_mem_clock;
		logic io_clock_domain;
		logic converter_clock_domain;
		logic async_timer_clock;
		logic usb_clock_domain;
		logic main_osc;
		logic timer_osc;
		logic pll_en;
	} clk_gate_t;
	// Wake requests; resets and interrupts are already enabled at source.
	typedef struct packed {
		logic ext_reset;
		logic wdt_reset;
		logic bod_reset;
		logic wdt_irq;
		logic twi_match;
		logic twi_irq;
		logic spm_ready;
		logic adc_done;
		logic other_io;
		logic usb_sync;
		logic [3:0] upper_ext_irq_lines;
		logic [3:0] upper_edge_irq;
		logic [3:0] lower_ext_irq_lines;
		logic pin_change;
		logic vbus_transition_irq;
		logic usb_wakeup_irq;
		logic id_transition_irq;
		logic host_wakeup_irq;
	} wake_src_t;
	// Timer 2 state and its interrupt mask bits.
	typedef struct packed {
		logic enabled;
		logic async_clk;
		logic ovf;
		logic cmp;
		logic ovf_ie;
		logic cmp_ie;
	} timer2_t;
endpackage

// ---- rtl/sleep_wait_timer.sv ----
// Down counter that holds a state for a loaded number of cycles.
// Assumes load is a one-cycle strobe on the same clock, count at least one.
`timescale 1ns/1ps
`default_nettype none
module sleep_wait_timer (
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic i_load,
	input wire logic [15:0] i_count,
	output logic o_done
);
	import sleep_pkg::*;
	logic [15:0] count; // Cycles left after the current one.
	logic busy; // A wait is in progress.
	// =====================================================
	// Counter
	// Loading N makes done rise in the N-th cycle after the load edge.
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			count <= `SLP_NO_WAIT;
			busy <= 1'b0;
		end else if (i_load) begin
			count <= i_count - 16'h0001;
			busy <= 1'b1;
		end else if (o_done) begin
			busy <= 1'b0;
		end else if (busy) begin
			count <= count - 16'h0001;
		end
	end
	// Done is combinational so the owner can leave on the same edge.
	assign o_done = busy && (count == `SLP_NO_WAIT);
endmodule // sleep_wait_timer
`default_nettype wire

// ---- rtl/sleep_wake_filter.sv ----
// Per-mode qualification of wake sources.
// Assumes pin-level sources are asynchronous, the rest are on mclk.
`timescale 1ns/1ps
`default_nettype none
module sleep_wake_filter (
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire sleep_pkg::wake_src_t i_src,
	input wire sleep_pkg::timer2_t i_t2,
	input wire logic i_gie,
	input wire sleep_pkg::mode_t i_mode,
	input wire logic i_armed,
	output logic o_irq_wake,
	output logic o_rst_wake
);
	import sleep_pkg::*;
	logic [9:0] pin_meta; // First stage, read only by the second.
	logic [9:0] pin_sync; // Pins safe to use.
	logic s_rst, s_pc; // Synced reset and pin change.
	logic [3:0] s_up, s_lo; // Synced external lines.
	logic t2_evt, t2_ok, other_w, w;
	wake_src_t edge_only; // The upper edge requests alone, for the edge check.
	// =====================================================
	// Pin synchroniser
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			pin_meta <= 10'h000;
			pin_sync <= 10'h000;
		end else begin
			pin_meta <= {i_src.ext_reset, i_src.upper_ext_irq_lines, i_src.lower_ext_irq_lines, i_src.pin_change};
			pin_sync <= pin_meta;
		end
	end
	assign {s_rst, s_up, s_lo, s_pc} = pin_sync;
	// =====================================================
	// Qualification
	// Timer 2 needs both its own enable and the global enable.
	assign t2_evt = i_gie && i_t2.enabled && ((i_t2.ovf && i_t2.ovf_ie) || (i_t2.cmp && i_t2.cmp_ie));
	// In noise reduction timer 2 only runs on its asynchronous clock.
	assign t2_ok = (i_mode == MODE_IDLE) || ((i_mode == MODE_QUIET) && i_t2.async_clk) ||
		(i_mode == MODE_PSAVE) || (i_mode == MODE_XSTBY);
	// Sources that wake from every mode, then mode-limited ones.
	assign other_w = (|s_lo) || s_pc || (|s_up) || i_src.twi_match || i_src.wdt_irq ||
		i_src.vbus_transition_irq || i_src.usb_wakeup_irq || i_src.id_transition_irq || i_src.host_wakeup_irq ||
		(((i_mode == MODE_IDLE) || (i_mode == MODE_QUIET)) &&
		(i_src.spm_ready || i_src.adc_done || i_src.usb_sync || i_src.twi_irq)) ||
		((i_mode == MODE_IDLE) && (i_src.other_io || (|i_src.upper_edge_irq)));
	assign w = other_w || (t2_ok && t2_evt);
	// Registered; only meaningful while the core is halted.
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_irq_wake <= 1'b0;
			o_rst_wake <= 1'b0;
		end else begin
			o_irq_wake <= i_armed && w;
			o_rst_wake <= s_rst || i_src.wdt_reset || i_src.bod_reset;
		end
	end
	// =====================================================
	// Checks
	// Built apart from the wake logic, so a wrong mode term cannot hide an edge wake.
	always_comb begin
		edge_only = '0;
		edge_only.upper_edge_irq = i_src.upper_edge_irq;
	end
	property p_edge_blocked;
		@(posedge i_mclk) disable iff (!i_rst_b)
		(i_armed && i_mode != MODE_IDLE && (|i_src.upper_edge_irq) && (i_src == edge_only) &&
			(pin_sync == 10'h000) && !t2_evt) |=> !o_irq_wake;
	endproperty
	a_edge_blocked: assert property (p_edge_blocked) else $error("edge woke outside idle");
	property p_t2_needs_gie;
		@(posedge i_mclk) disable iff (!i_rst_b)
		(i_armed && i_mode == MODE_PSAVE && !i_gie && !other_w) |=> !o_irq_wake;
	endproperty
	a_t2_needs_gie: assert property (p_t2_needs_gie) else $error("timer 2 woke without global enable");
endmodule // sleep_wake_filter
`default_nettype wire

// ---- rtl/sleep_mode_controller.sv ----
// Sleep mode controller: entry, clock gating, wake and restart sequencing.
// Assumes the core strobes i_sleep_instr for one mclk cycle per sleep
// instruction and honours o_core_halt; peripherals obey o_gates.
`timescale 1ns/1ps
`default_nettype none
module sleep_mode_controller #(
	// Clock restart period after power-down and power-save.
	parameter logic [15:0] STARTUP_CYCLES = `SLP_STARTUP_CYCLES
) (
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic [2:0] i_sleep_mode_select,
	input wire logic i_sleep_enable_bit,
	input wire logic i_sleep_instr,
	input wire logic [3:0] i_clock_source_select,
	input wire logic i_converter_enabled,
	input wire logic i_global_irq_enable,
	input wire sleep_pkg::timer2_t i_timer2,
	input wire sleep_pkg::wake_src_t i_wake_src,
	output sleep_pkg::clk_gate_t o_gates,
	output logic o_core_halt,
	output logic o_sleeping,
	output sleep_pkg::mode_t o_active_mode,
	output logic o_converter_start,
	output logic o_irq_service,
	output logic o_reset_restart
);
	import sleep_pkg::*;
	run_state_t state; // Current run state.
	run_state_t next_state; // State after this edge.
	mode_t sleep_mode; // Mode latched when sleep was entered.
	mode_t sel_mode; // Mode select seen as an enum.
	logic enter; // Sleep instruction accepted this cycle.
	logic irq_wake; // Qualified interrupt wake, registered.
	logic rst_wake; // Some reset source is active, registered.
	logic tmr_load; // Start a wait in the timer.
	logic [15:0] tmr_count; // Length of that wait.
	logic tmr_done; // Wait has run out.

	// =====================================================
	// Decoding helpers
	// Reserved codes and crystal-less standby act as no sleep at all.
	function automatic logic sleep_allowed(input mode_t m, input logic [3:0] css);
		logic ok;
		ok = 1'b1;
		if ((m == MODE_RSV4) || (m == MODE_RSV5)) begin
			ok = 1'b0;
		end else if ((m == MODE_STBY) || (m == MODE_XSTBY)) begin
			ok = css[`SLP_XTAL_BIT];
		end
		return ok;
	endfunction

	// Start-up wait for a mode; zero means go straight to the halt.
	function automatic logic [15:0] wake_cycles(input mode_t m);
		logic [15:0] n;
		n = `SLP_NO_WAIT;
		if ((m == MODE_PDOWN) || (m == MODE_PSAVE)) begin
			n = STARTUP_CYCLES;
		end else if ((m == MODE_STBY) || (m == MODE_XSTBY)) begin
			n = `SLP_STANDBY_WAKE;
		end
		return n;
	endfunction

	// Clock enables for a state and mode.
	function automatic clk_gate_t gates_for(input run_state_t st, input mode_t m, input timer2_t t2);
		clk_gate_t g;
		g = '1;
		g.timer_osc = t2.async_clk;
		if (st == ST_SLEEP) begin
			case (m)
				MODE_IDLE: begin
					g.core_clock_domain = 1'b0;
					g.program_mem_clock = 1'b0;
				end
				MODE_QUIET: begin
					g.core_clock_domain = 1'b0;
					g.program_mem_clock = 1'b0;
					g.io_clock_domain = 1'b0;
				end
				MODE_PDOWN: begin
					g = '0;
				end
				MODE_PSAVE: begin
					// The main source only stays up to feed a synchronous timer 2.
					g = '0;
					g.async_timer_clock = 1'b1;
					g.timer_osc = t2.async_clk;
					g.main_osc = t2.enabled && !t2.async_clk;
				end
				MODE_STBY: begin
					// Oscillator on, but the PLL and so USB stay off.
					g = '0;
					g.main_osc = 1'b1;
				end
				MODE_XSTBY: begin
					g = '0;
					g.main_osc = 1'b1;
					g.async_timer_clock = t2.async_clk;
					g.timer_osc = t2.async_clk;
				end
				default: begin
					g = '1;
				end
			endcase
		end else if (st != ST_ACTIVE) begin
			// Clocks restart while the core itself stays held.
			g.core_clock_domain = 1'b0;
			g.program_mem_clock = 1'b0;
		end
		return g;
	endfunction

	// =====================================================
	// Wake filter and wait timer
	sleep_wake_filter u_filter (
		.i_mclk(i_mclk),
		.i_rst_b(i_rst_b),
		.i_src(i_wake_src),
		.i_t2(i_timer2),
		.i_gie(i_global_irq_enable),
		.i_mode(sleep_mode),
		.i_armed(state == ST_SLEEP),
		.o_irq_wake(irq_wake),
		.o_rst_wake(rst_wake)
	);

	sleep_wait_timer u_timer (
		.i_mclk(i_mclk),
		.i_rst_b(i_rst_b),
		.i_load(tmr_load),
		.i_count(tmr_count),
		.o_done(tmr_done)
	);

	// =====================================================
	// Entry decision
	// The instruction is a no-op unless enabled and the code is usable.
	assign sel_mode = mode_t'(i_sleep_mode_select);
	assign enter = (state == ST_ACTIVE) && i_sleep_instr && i_sleep_enable_bit &&
		sleep_allowed(sel_mode, i_clock_source_select);

	// =====================================================
	// State machine
	// A reset source beats any interrupt and ends every wait at once.
	always_comb begin
		next_state = state;
		case (state)
			ST_ACTIVE: begin
				if (enter) begin
					next_state = ST_SLEEP;
				end
			end
			ST_SLEEP: begin
				if (rst_wake) begin
					next_state = ST_ACTIVE;
				end else if (irq_wake) begin
					if (wake_cycles(sleep_mode) != `SLP_NO_WAIT) begin
						next_state = ST_STARTUP;
					end else begin
						next_state = ST_HALT;
					end
				end
			end
			ST_STARTUP: begin
				if (rst_wake) begin
					next_state = ST_ACTIVE;
				end else if (tmr_done) begin
					next_state = ST_HALT;
				end
			end
			ST_HALT: begin
				if (rst_wake || tmr_done) begin
					next_state = ST_ACTIVE;
				end
			end
			default: begin
				next_state = ST_ACTIVE;
			end
		endcase
	end

	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			state <= ST_ACTIVE;
		end else begin
			state <= next_state;
		end
	end

	// Mode is frozen at entry so later writes cannot change an ongoing sleep.
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			sleep_mode <= MODE_IDLE;
		end else if (enter) begin
			sleep_mode <= sel_mode;
		end
	end

	// =====================================================
	// Wait loading
	// Each wait starts on the edge that enters its state.
	assign tmr_load = (state != next_state) && ((next_state == ST_STARTUP) || (next_state == ST_HALT));
	assign tmr_count = (next_state == ST_STARTUP) ? wake_cycles(sleep_mode) : `SLP_HALT_CYCLES;

	// =====================================================
	// Outputs
	// These outputs are flops fed from the next state and mode so they line up with state.
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_gates <= '1;
			o_core_halt <= 1'b0;
			o_sleeping <= 1'b0;
			o_active_mode <= MODE_IDLE;
		end else begin
			o_gates <= gates_for(next_state, enter ? sel_mode : sleep_mode, i_timer2);
			o_core_halt <= (next_state != ST_ACTIVE);
			o_sleeping <= (next_state == ST_SLEEP);
			o_active_mode <= enter ? sel_mode : sleep_mode;
		end
	end

	// One-cycle event strobes.
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_converter_start <= 1'b0;
			o_irq_service <= 1'b0;
			o_reset_restart <= 1'b0;
		end else begin
			o_converter_start <= enter && i_converter_enabled &&
				((sel_mode == MODE_IDLE) || (sel_mode == MODE_QUIET));
			o_irq_service <= (state == ST_HALT) && tmr_done && !rst_wake;
			o_reset_restart <= (state != ST_ACTIVE) && rst_wake;
		end
	end

	// =====================================================
	// Checks
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_b);

	property p_idle_gates;
		(state == ST_SLEEP && sleep_mode == MODE_IDLE) |->
			(!o_gates.core_clock_domain && !o_gates.program_mem_clock && o_gates.io_clock_domain &&
			o_gates.converter_clock_domain && o_gates.main_osc);
	endproperty
	a_idle_gates: assert property (p_idle_gates) else $error("idle clock gates wrong");

	property p_quiet_gates;
		(state == ST_SLEEP && sleep_mode == MODE_QUIET) |->
			(!o_gates.io_clock_domain && o_gates.converter_clock_domain && o_gates.usb_clock_domain);
	endproperty
	a_quiet_gates: assert property (p_quiet_gates) else $error("quiet mode clock gates wrong");

	property p_no_enable;
		(state == ST_ACTIVE && i_sleep_instr && !i_sleep_enable_bit) |=> (state == ST_ACTIVE);
	endproperty
	a_no_enable: assert property (p_no_enable) else $error("slept without enable");

	property p_reserved;
		(state == ST_ACTIVE && (sel_mode == MODE_RSV4 || sel_mode == MODE_RSV5)) |=> !o_sleeping;
	endproperty
	a_reserved: assert property (p_reserved) else $error("slept on reserved code");

	property p_conv_start;
		(enter && i_converter_enabled && sel_mode == MODE_QUIET) |=> o_converter_start ##1 !o_converter_start;
	endproperty
	a_conv_start: assert property (p_conv_start) else $error("no single conversion start");

	property p_halt_four;
		(state != ST_HALT ##1 state == ST_HALT && !rst_wake) |->
			(state == ST_HALT && !rst_wake)[*4] ##1 (state == ST_ACTIVE && o_irq_service);
	endproperty
	a_halt_four: assert property (p_halt_four) else $error("halt not four cycles");

	property p_stby_six;
		(state == ST_SLEEP ##1 state == ST_STARTUP && sleep_mode == MODE_STBY && !rst_wake)
			|-> (state == ST_STARTUP && !rst_wake)[*6] ##1 (state == ST_HALT);
	endproperty
	a_stby_six: assert property (p_stby_six) else $error("standby wake not six cycles");

	property p_stby_pll;
		(state == ST_SLEEP && sleep_mode == MODE_STBY) |-> (!o_gates.pll_en && !o_gates.usb_clock_domain && o_gates.main_osc);
	endproperty
	a_stby_pll: assert property (p_stby_pll) else $error("pll running in standby");

	property p_ps_timer_osc;
		(state == ST_SLEEP && sleep_mode == MODE_PSAVE && !$past(i_timer2.async_clk)) |-> !o_gates.timer_osc;
	endproperty
	a_ps_timer_osc: assert property (p_ps_timer_osc) else $error("timer osc on in power-save");

	property p_reset_wake;
		(state != ST_ACTIVE && rst_wake) |=> (state == ST_ACTIVE && o_reset_restart && !o_core_halt);
	endproperty
	a_reset_wake: assert property (p_reset_wake) else $error("reset did not restart core");

	c_idle_cycle: cover property (state == ST_SLEEP && sleep_mode == MODE_IDLE ##1 state == ST_HALT);
	c_pd_startup: cover property (state == ST_SLEEP && sleep_mode == MODE_PDOWN ##1 state == ST_STARTUP);
	c_xstby_wake: cover property (state == ST_STARTUP && sleep_mode == MODE_XSTBY ##1 state == ST_HALT);
	c_reset_out: cover property (o_reset_restart);
endmodule // sleep_mode_controller
`default_nettype wire

// ---- dv/sleep_core_model.sv ----
// Core model: turns a request level into one-cycle sleep instruction pulses, every other cycle until halted.
// Assumes the request is driven on the rising edge of the same clock.
`timescale 1ns/1ps
`default_nettype none
module sleep_core_model (
	input wire logic i_mclk,
	input wire logic i_rst_b,
	input wire logic i_req,
	input wire logic i_core_halt,
	output logic o_sleep_instr
);
	// =====================================================
	// Instruction issue
	// A halted core fetches nothing, so it never issues while halted.
	// The pulse lasts one cycle because a core executes one sleep at a time.
	always_ff @(posedge i_mclk or negedge i_rst_b) begin
		if (!i_rst_b) begin
			o_sleep_instr <= 1'h0;
		end else begin
			o_sleep_instr <= i_req & ~i_core_halt & ~o_sleep_instr;
		end
	end
endmodule // sleep_core_model
`default_nettype wire

// ---- dv/tb_sleep_mode_controller.sv ----
// Testbench for the sleep mode controller: entry, clock gating, wake and refusal.
// Assumes the controller carries its own assertions and the core model issues sleeps.
`timescale 1ns/1ps
`default_nettype none
module tb_sleep_mode_controller;
	import sleep_pkg::*;
	// =====================================================
	// Signals
	localparam logic [15:0] SU = 16'h0008; // Short restart period keeps the run brief.
	logic i_mclk = 1'h0;
	logic rst_b = 1'h0;
	logic [2:0] sel = 3'h0;
	logic se = 1'h0;
	logic [3:0] css = 4'h0;
	logic cen = 1'h0;
	logic gie = 1'h0;
	logic req = 1'h0;
	logic instr;
	timer2_t t2 = '0;
	wake_src_t ws = '0;
	clk_gate_t gates;
	mode_t amode;
	logic halt, slp, cst, svc, rrs;
	int error_cnt = 0;
	int checked = 0;
	// Mode, source bit and whether that source may wake that mode.
	int cm[10] = '{0, 1, 1, 2, 2, 3, 6, 7, 0, 1};
	int ck[10] = '{18, 18, 19, 20, 22, 17, 9, 21, 9, 13};
	bit ca[10] = '{1, 0, 1, 0, 1, 0, 0, 0, 1, 1};
	always #2.5 i_mclk = ~i_mclk;
	sleep_mode_controller #(.STARTUP_CYCLES(SU)) i_dut (
		.i_mclk(i_mclk), .i_rst_b(rst_b), .i_sleep_mode_select(sel),
		.i_sleep_enable_bit(se), .i_sleep_instr(instr), .i_clock_source_select(css),
		.i_converter_enabled(cen), .i_global_irq_enable(gie), .i_timer2(t2),
		.i_wake_src(ws), .o_gates(gates), .o_core_halt(halt), .o_sleeping(slp),
		.o_active_mode(amode), .o_converter_start(cst), .o_irq_service(svc),
		.o_reset_restart(rrs));
	sleep_core_model i_core (.i_mclk(i_mclk), .i_rst_b(rst_b), .i_req(req),
		.i_core_halt(halt), .o_sleep_instr(instr));
	// =====================================================
	// Expectations
	// Gate pattern per mode; the timer oscillator follows the async timer bit outside power-down and standby.
	function automatic clk_gate_t exp_gates(input int m, input logic a, input logic e);
		case (m)
			0: return {2'h0, 5'h1f, a, 1'h1};
			1: return {3'h0, 4'hf, a, 1'h1};
			3: return {4'h0, 1'h1, 1'h0, e & ~a, a, 1'h0};
			6: return {6'h00, 1'h1, 2'h0};
			7: return {4'h0, a, 1'h0, 1'h1, a, 1'h0};
			default: return '0;
		endcase
	endfunction
	// Cycles from the sampling edge to release; pin sources pass two sync flops.
	function automatic int lat(input int m, input int k);
		int b;
		// One cycle to register the wake, then the restart wait, then four halt cycles.
		b = (m < 2) ? 1 + 4 : ((m < 4) ? 1 + SU + 4 : 1 + 6 + 4);
		return b + (((k >= 4 && k <= 8) || (k >= 13 && k <= 16)) ? 2 : 0);
	endfunction
	function automatic wake_src_t one_src(input int k);
		return wake_src_t'(27'h000_0001 << k);
	endfunction
	// =====================================================
	// Drivers and compares
	task automatic tick();
		@(posedge i_mclk);
	endtask
	task automatic cmp_bit(input logic e, input logic g);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic cmp_gates(input clk_gate_t e, input clk_gate_t g);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	task automatic cmp_cnt(input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask
	// Requests one sleep and checks the state one cycle after it is taken.
	task automatic enter(input int m, input logic en, input logic xt);
		logic ok;
		ok = en & !(m inside {4, 5}) & (xt | (m < 6));
		tick();
		sel <= m[2:0];
		se <= en;
		css <= {xt, 3'($urandom)};
		cen <= 1'($urandom);
		t2 <= '{enabled: 1'($urandom), async_clk: 1'($urandom), default: 1'h0};
		req <= 1'h1;
		tick();
		req <= 1'h0;
		tick();
		#1;
		cmp_bit(ok, slp);
		if (ok) begin
			cmp_gates(exp_gates(m, t2.async_clk, t2.enabled), gates);
			cmp_cnt(m[7:0], {5'h00, amode});
			cmp_bit(cen & (m < 2), cst);
		end
	endtask
	// A wake source is high for exactly one sample.
	task automatic pulse(input int k);
		tick();
		ws <= one_src(k);
		tick();
		ws <= '0;
	endtask
	// Counts edges until the service or restart pulse, bounded.
	task automatic wait_pulse(input logic r, input int e);
		int k;
		k = 0;
		do begin
			tick();
			#1;
			k++;
		end while (k < 40 && (r ? rrs : svc) !== 1'h1);
		cmp_cnt(e[7:0], k[7:0]);
		cmp_bit(1'h0, halt);
	endtask
	task automatic results();
		if (error_cnt == 0 && checked > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// =====================================================
	// Tests
	initial begin
		void'($urandom(30));
		repeat (5) tick();
		rst_b <= 1'h1;
		// Every encoding twice; each one that sleeps is woken by a random async USB source.
		for (int p = 0; p < 16; p++) begin
			enter(p % 8, 1'h1, 1'h1);
			if (slp === 1'h1) begin
				pulse($urandom_range(3, 0));
				wait_pulse(1'h0, lat(p % 8, 0));
			end
		end
		enter(0, 1'h0, 1'h1);
		enter(6, 1'h1, 1'h0);
		enter(7, 1'h1, 1'h0);
		// Allowed and refused sources; a refused one is followed by a watchdog wake.
		for (int i = 0; i < 10; i++) begin
			enter(cm[i], 1'h1, 1'h1);
			pulse(ck[i]);
			if (ca[i]) begin
				wait_pulse(1'h0, lat(cm[i], ck[i]));
			end else begin
				repeat (20) tick();
				#1;
				cmp_bit(1'h1, slp);
				pulse(23);
				wait_pulse(1'h0, lat(cm[i], 23));
			end
		end
		// A running timer 2 event in power-save wakes only with the global enable.
		// The overflow lacks its own enable, so only the compare event may count.
		enter(3, 1'h1, 1'h1);
		tick();
		t2 <= '{enabled: 1'h1, async_clk: 1'h1, ovf: 1'h1, cmp: 1'h1, cmp_ie: 1'h1, default: 1'h0};
		repeat (20) tick();
		#1;
		cmp_bit(1'h1, slp);
		tick();
		gie <= 1'h1;
		// The enable lands one edge before the edge that samples the event.
		wait_pulse(1'h0, lat(3, 0) + 1);
		tick();
		t2 <= '0;
		// A reset source during sleep restarts the core.
		enter(7, 1'h1, 1'h1);
		pulse(25);
		wait_pulse(1'h1, 1);
		results();
	end
	// Cuts a hang short well beyond the few hundred cycles the tests take.
	initial begin
		#50000;
		error_cnt++;
		results();
	end
endmodule // tb_sleep_mode_controller
`default_nettype wire
